//--- video_decoder_output_port.sv
// Digital output port: luma and 4:2:2 chroma buses with sync and flags.
//
// How it works
// R1: Every flip-flop runs on the single master clock and all pins are synchronous to it.
// R2: The reset input clears all state except the FIFO storage asynchronously to its default values.
// R3: Chroma samples leave as unsigned codes over the full range 0 to 255.
// R4: Luma samples leave as unsigned codes held within 16 to 255.
// R5: The chroma bus alternates blue then red difference samples, each line starting with blue.
// R6: The data-valid output is high exactly in the cycles that carry a valid sample.
// R7: After hardware or software reset the valid, sync, field and active outputs float.
// R8: Line sync follows detected input sync, or the pixel counter overflow without video.
// R9: The start and end positions of the line sync pulse are programmable.
// R10: Frame sync follows detected input sync, or the line counter overflow without video.
// R11: The field flag is low for an odd field and high for an even field.
// R12: With no vertical sync seen, the field flag toggles after 337 lines.
// R13: The active flag is high while active-line samples are on the buses.
// R14: In burst output mode the active flag is held high.
// R15: The active flag is free running and updated on every master clock edge.
// R16: The receiver captures samples only while data-valid is high and uses the flags for framing.
module video_decoder_output_port (
  input  wire logic                               clk_i,
  input  wire logic                               reset_i,
  input  wire logic                               soft_reset_i,
  input  wire logic                               output_enable_i,
  input  wire logic                               burst_mode_i,
  input  wire logic                               video_present_i,
  input  wire logic                               hsync_detect_i,
  input  wire logic                               vsync_detect_i,
  input  wire logic [video_out_pkg::PIX_W-1:0]    hsync_start_i,
  input  wire logic [video_out_pkg::PIX_W-1:0]    hsync_end_i,
  input  wire logic                               pixel_valid_i,
  input  wire logic                               pixel_active_i,
  input  wire logic [video_out_pkg::SAMPLE_W-1:0] luma_in_i,
  input  wire logic [video_out_pkg::SAMPLE_W-1:0] cb_in_i,
  input  wire logic [video_out_pkg::SAMPLE_W-1:0] cr_in_i,
  input  wire logic                               drain_hold_i,
  output logic                                    pixel_ready_o,
  output logic [video_out_pkg::SAMPLE_W-1:0]      luma_out_o,
  output logic [video_out_pkg::SAMPLE_W-1:0]      chroma_out_bus_o,
  output logic                                    sample_valid_out_o,
  output logic                                    sample_valid_out_oe_o,
  output logic                                    hsync_o,
  output logic                                    hsync_oe_o,
  output logic                                    vsync_o,
  output logic                                    vsync_oe_o,
  output logic                                    field_o,
  output logic                                    field_oe_o,
  output logic                                    active_o,
  output logic                                    active_oe_o
);
  sample_fifo_if #(.WIDTH(video_out_pkg::WORD_W)) fifo_bus ();

  video_out_pkg::out_state_t out_state;
  logic                                 drive_pins;
  logic                                 line_start;
  logic                                 timer_hsync;
  logic                                 timer_vsync;
  logic                                 timer_field;
  logic                                 red_next;
  logic                                 take_cb;
  logic                                 push;
  logic                                 pop;
  logic [video_out_pkg::SAMPLE_W-1:0]   chroma_sel;

  line_lock_timer timer (
    .clk_i           (clk_i),
    .reset_i         (reset_i),
    .soft_reset_i    (soft_reset_i),
    .video_present_i (video_present_i),
    .hsync_detect_i  (hsync_detect_i),
    .vsync_detect_i  (vsync_detect_i),
    .hsync_start_i   (hsync_start_i),
    .hsync_end_i     (hsync_end_i),
    .line_start_o    (line_start),
    .hsync_o         (timer_hsync),
    .vsync_o         (timer_vsync),
    .field_o         (timer_field)
  );

  // Soft reset also empties the FIFO so no stale line leaks out
  sample_fifo #(
    .WIDTH (video_out_pkg::WORD_W),
    .DEPTH (video_out_pkg::FIFO_DEPTH)
  ) fifo (
    .clk_i   (clk_i),
    .reset_i (reset_i),
    .flush_i (soft_reset_i),
    .bus     (fifo_bus.fifo)
  );

  // A line start forces blue, even when it lands on a push
  assign take_cb    = line_start || !red_next;                                 // R5
  assign chroma_sel = take_cb ? cb_in_i : cr_in_i;                             // R3
  assign push       = fifo_bus.wvalid && fifo_bus.wready;
  assign pop        = fifo_bus.rvalid && fifo_bus.rready;

  assign fifo_bus.wvalid = pixel_valid_i && !soft_reset_i;
  assign fifo_bus.rready = !drain_hold_i;
  assign fifo_bus.wdata  = {pixel_active_i, chroma_sel,
                            video_out_pkg::clamp_luma(luma_in_i)};             // R4

  // Ready is the FIFO's registered not-full flag
  assign pixel_ready_o = fifo_bus.wready;

  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
      red_next <= 1'b0;                                                        // R2
    else if (soft_reset_i)
      red_next <= 1'b0;
    else if (push)
      red_next <= take_cb;                                                     // R5
    else if (line_start)
      red_next <= 1'b0;
  end

  // Pin drivers stay off until software enables them after any reset
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
      out_state <= video_out_pkg::OUT_HIZ;                                     // R7
    else
    begin
      case (out_state)
        video_out_pkg::OUT_HIZ:
          if (output_enable_i && !soft_reset_i)
            out_state <= video_out_pkg::OUT_DRIVE;
        video_out_pkg::OUT_DRIVE:
          if (soft_reset_i)
            out_state <= video_out_pkg::OUT_HIZ;                               // R7
        default:
          out_state <= video_out_pkg::OUT_HIZ;
      endcase
    end
  end

  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
      drive_pins <= 1'b0;
    else
      drive_pins <= (out_state == video_out_pkg::OUT_DRIVE) && !soft_reset_i;  // R7
  end

  assign sample_valid_out_oe_o = drive_pins;
  assign hsync_oe_o            = drive_pins;
  assign vsync_oe_o            = drive_pins;
  assign field_oe_o            = drive_pins;
  assign active_oe_o           = drive_pins;

  // Data buses hold the last sample between valid cycles
  always_ff @(posedge clk_i or posedge reset_i)                                // R1
  begin
    if (reset_i)
    begin
      luma_out_o         <= video_out_pkg::LUMA_MIN;
      chroma_out_bus_o   <= '0;
      sample_valid_out_o <= 1'b0;
    end
    else if (soft_reset_i)
    begin
      sample_valid_out_o <= 1'b0;
    end
    else
    begin
      sample_valid_out_o <= pop;                                               // R6
      if (pop)
      begin
        luma_out_o       <= fifo_bus.rdata[video_out_pkg::LUMA_LSB +: video_out_pkg::SAMPLE_W];
        chroma_out_bus_o <= fifo_bus.rdata[video_out_pkg::CHROMA_LSB +: video_out_pkg::SAMPLE_W];
      end
    end
  end

  // Updated every edge; outside burst mode a stalled drain shows as inactive
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
      active_o <= 1'b0;
    else if (soft_reset_i)
      active_o <= 1'b0;
    else
      active_o <= burst_mode_i ||                                              // R14
                  (pop && fifo_bus.rdata[video_out_pkg::ACTIVE_BIT]);          // R13 R15
  end

  // Sync flags registered to keep every pin on a local flip-flop
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      hsync_o <= 1'b0;
      vsync_o <= 1'b0;
      field_o <= 1'b0;
    end
    else
    begin
      hsync_o <= timer_hsync;                                                  // R8
      vsync_o <= timer_vsync;                                                  // R10
      field_o <= timer_field;                                                  // R11
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  luma_floor_a: assert property (sample_valid_out_o |-> luma_out_o >= video_out_pkg::LUMA_MIN) // R4
    else $error("luma below floor on output bus");
  valid_source_a: assert property (sample_valid_out_o |-> $past(fifo_bus.rvalid && !drain_hold_i)) // R6
    else $error("valid asserted without a popped sample");
  valid_pop_a: assert property (pop && !soft_reset_i |=> sample_valid_out_o) // R6
    else $error("popped sample not flagged valid");
  line_cb_a: assert property (push && line_start |-> // R5
                              fifo_bus.wdata[video_out_pkg::CHROMA_LSB +: video_out_pkg::SAMPLE_W]
                              == cb_in_i)
    else $error("line did not start with blue difference");
  chroma_alt_a: assert property (push && take_cb && !soft_reset_i ##1 push && !line_start // R5
                                 |-> !take_cb)
    else $error("chroma did not alternate");
  chroma_pass_a: assert property (pop && !soft_reset_i |=> chroma_out_bus_o == // R3
                                  $past(fifo_bus.rdata[video_out_pkg::CHROMA_LSB +:
                                  video_out_pkg::SAMPLE_W]))
    else $error("chroma sample altered on output");
  soft_hiz_a: assert property (soft_reset_i |=> !drive_pins ##1 !drive_pins) // R7
    else $error("pins driven after soft reset");
  burst_active_a: assert property (burst_mode_i && !soft_reset_i |=> active_o) // R14
    else $error("active not held in burst mode");
  active_follow_a: assert property (!burst_mode_i && !soft_reset_i |=> active_o == // R13
                                    $past(pop && fifo_bus.rdata[video_out_pkg::ACTIVE_BIT]))
    else $error("active flag does not match sample");
  field_pass_a: assert property (!soft_reset_i ##1 !soft_reset_i |-> field_o == $past(timer_field)) // R11
    else $error("field pin lags timer");

  fifo_full_c: cover property (!fifo_bus.wready ##1 pop);
  active_out_c: cover property (sample_valid_out_o && active_o && drive_pins);
  enable_c: cover property (output_enable_i ##2 drive_pins);
  line_cb_c: cover property (push && line_start ##1 push);
endmodule : video_decoder_output_port

//--- video_out_pkg.sv
// Constants, word layout and types shared by the video output port.
package video_out_pkg;

  localparam int SAMPLE_W = 8;
  localparam int PIX_W    = 10;
  localparam int WORD_W   = 17;

  // Layout of one FIFO word
  localparam int LUMA_LSB   = 0;
  localparam int CHROMA_LSB = 8;
  localparam int ACTIVE_BIT = 16;

  localparam int FIFO_DEPTH = 16;

  // Luma code floor; chroma uses the full 8-bit range
  localparam logic [SAMPLE_W-1:0] LUMA_MIN = 8'h10;

  // Line lock constants; the line and field lengths are used only without input video
  localparam logic [PIX_W-1:0] LINE_PIXELS_MAX    = 10'h35A;
  localparam logic [PIX_W-1:0] FIELD_LINES_MAX    = 10'h107;
  localparam logic [PIX_W-1:0] FIELD_TOGGLE_LINES = 10'h151;
  localparam logic [PIX_W-1:0] VSYNC_LINES        = 10'h003;
  localparam logic [PIX_W-1:0] COUNT_ZERO         = 10'h000;
  localparam logic [PIX_W-1:0] COUNT_STEP         = 10'h001;

  typedef enum logic [1:0]
  {
    OUT_HIZ   = 2'b01,
    OUT_DRIVE = 2'b10
  } out_state_t;

  function automatic logic [SAMPLE_W-1:0] clamp_luma(input logic [SAMPLE_W-1:0] y);
    clamp_luma = (y < LUMA_MIN) ? LUMA_MIN : y;
  endfunction : clamp_luma

endpackage : video_out_pkg

//--- sample_fifo_if.sv
// Push and pop signals between the output port and its sample FIFO.
interface sample_fifo_if #(parameter int WIDTH = 17);
  logic [WIDTH-1:0] wdata;
  logic             wvalid;
  logic             wready;
  logic [WIDTH-1:0] rdata;
  logic             rvalid;
  logic             rready;

  modport fifo
  (
    input  wdata,
    input  wvalid,
    input  rready,
    output wready,
    output rdata,
    output rvalid
  );
  modport user
  (
    output wdata,
    output wvalid,
    output rready,
    input  wready,
    input  rdata,
    input  rvalid
  );
endinterface : sample_fifo_if

//--- sample_fifo.sv
// Sample FIFO with registered full flag and a synchronous flush.
module sample_fifo #(
  parameter int WIDTH = 17,
  parameter int DEPTH = 16
) (
  input  wire logic       clk_i,
  input  wire logic       reset_i,
  input  wire logic       flush_i,
  sample_fifo_if.fifo     bus
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_COUNT = (AW+1)'(DEPTH);
  localparam logic [AW:0] ONE = (AW+1)'(1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic [AW:0]      next_count;
  logic             push;
  logic             pop;

  assign push = bus.wvalid && bus.wready;
  assign pop  = bus.rvalid && bus.rready;
  assign bus.rvalid = (count != '0);
  assign bus.rdata  = mem[rd_ptr];

  always_comb
  begin
    next_count = count;
    if (push && !pop)
      next_count = count + ONE;
    else if (pop && !push)
      next_count = count - ONE;
  end

  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      wr_ptr     <= '0;
      rd_ptr     <= '0;
      count      <= '0;
      bus.wready <= 1'b1;
    end
    else if (flush_i)
    begin
      wr_ptr     <= '0;
      rd_ptr     <= '0;
      count      <= '0;
      bus.wready <= 1'b1;
    end
    else
    begin
      if (push)
        wr_ptr <= wr_ptr + AW'(1);
      if (pop)
        rd_ptr <= rd_ptr + AW'(1);
      count      <= next_count;
      bus.wready <= (next_count != FULL_COUNT);
    end
  end

  // Storage needs no reset; only entries below count are ever read
  always_ff @(posedge clk_i)
  begin
    if (push)
      mem[wr_ptr] <= bus.wdata;
  end
endmodule : sample_fifo

//--- line_lock_timer.sv
// Line and field timing: sync pulses, field flag, free-run fallback.
module line_lock_timer (
  input  wire logic                             clk_i,
  input  wire logic                             reset_i,
  input  wire logic                             soft_reset_i,
  input  wire logic                             video_present_i,
  input  wire logic                             hsync_detect_i,
  input  wire logic                             vsync_detect_i,
  input  wire logic [video_out_pkg::PIX_W-1:0]  hsync_start_i,
  input  wire logic [video_out_pkg::PIX_W-1:0]  hsync_end_i,
  output logic                                  line_start_o,
  output logic                                  hsync_o,
  output logic                                  vsync_o,
  output logic                                  field_o
);
  logic [video_out_pkg::PIX_W-1:0] pix_cnt;
  logic [video_out_pkg::PIX_W-1:0] line_cnt;
  logic [video_out_pkg::PIX_W-1:0] since_vsync;
  logic                            vsync_event;
  logic                            field_timeout;

  // Detected sync steers timing; pixel and line counters overflow only with no video, the field timeout counter with or without video
  assign line_start_o = video_present_i ? hsync_detect_i                       // R8
                      : (pix_cnt == video_out_pkg::LINE_PIXELS_MAX - video_out_pkg::COUNT_STEP);
  assign vsync_event  = video_present_i ? vsync_detect_i                       // R10
                      : (line_start_o && line_cnt == video_out_pkg::FIELD_LINES_MAX
                         - video_out_pkg::COUNT_STEP);
  assign field_timeout = line_start_o && !vsync_detect_i &&                    // R12
                         (since_vsync == video_out_pkg::FIELD_TOGGLE_LINES - video_out_pkg::COUNT_STEP);

  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      pix_cnt  <= video_out_pkg::COUNT_ZERO;
      line_cnt <= video_out_pkg::COUNT_ZERO;
    end
    else if (soft_reset_i)
    begin
      pix_cnt  <= video_out_pkg::COUNT_ZERO;
      line_cnt <= video_out_pkg::COUNT_ZERO;
    end
    else
    begin
      pix_cnt <= line_start_o ? video_out_pkg::COUNT_ZERO : pix_cnt + video_out_pkg::COUNT_STEP;
      if (vsync_event)
        line_cnt <= video_out_pkg::COUNT_ZERO;
      else if (line_start_o)
        line_cnt <= line_cnt + video_out_pkg::COUNT_STEP;
    end
  end

  // Start wins when both positions are equal, so the pulse is never cleared
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
      hsync_o <= 1'b0;
    else if (soft_reset_i)
      hsync_o <= 1'b0;
    else if (pix_cnt == hsync_start_i)                                         // R9
      hsync_o <= 1'b1;
    else if (pix_cnt == hsync_end_i)                                           // R9
      hsync_o <= 1'b0;
  end

  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
      vsync_o <= 1'b0;
    else if (soft_reset_i)
      vsync_o <= 1'b0;
    else if (vsync_event)                                                      // R10
      vsync_o <= 1'b1;
    else if (line_start_o && line_cnt + video_out_pkg::COUNT_STEP >= video_out_pkg::VSYNC_LINES)
      vsync_o <= 1'b0;
  end

  // Low for odd field, high for even field
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      field_o     <= 1'b0;
      since_vsync <= video_out_pkg::COUNT_ZERO;
    end
    else if (soft_reset_i)
    begin
      field_o     <= 1'b0;
      since_vsync <= video_out_pkg::COUNT_ZERO;
    end
    else if (vsync_detect_i)
    begin
      field_o     <= ~field_o;                                                 // R11
      since_vsync <= video_out_pkg::COUNT_ZERO;
    end
    else if (field_timeout)
    begin
      field_o     <= ~field_o;                                                 // R12
      since_vsync <= video_out_pkg::COUNT_ZERO;
    end
    else if (line_start_o)
      since_vsync <= since_vsync + video_out_pkg::COUNT_STEP;
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  hsync_start_a: assert property ((pix_cnt == hsync_start_i) && !soft_reset_i |=> hsync_o) // R9
    else $error("hsync did not start at programmed position");
  hsync_end_a: assert property ((pix_cnt == hsync_end_i) && (pix_cnt != hsync_start_i) // R9
                                && !soft_reset_i |=> !hsync_o)
    else $error("hsync did not end at programmed position");
  free_line_a: assert property (!video_present_i && !soft_reset_i && (pix_cnt == // R8
                                video_out_pkg::LINE_PIXELS_MAX - video_out_pkg::COUNT_STEP)
                                |=> pix_cnt == video_out_pkg::COUNT_ZERO)
    else $error("free-running line counter did not overflow");
  vsync_rise_a: assert property (vsync_event && !soft_reset_i |=> vsync_o) // R10
    else $error("vsync pulse missing after vertical event");
  field_timeout_a: assert property (field_timeout && !soft_reset_i |=> field_o != $past(field_o)) // R12
    else $error("field flag did not toggle after line timeout");
  field_cover_c: cover property (field_timeout ##1 field_o);
endmodule : line_lock_timer

//--- video_sink_model.sv
// Frame-store side model: pulled-up pins and a drain that may stall.
module video_sink_model (
  input  wire logic       clk_i,
  input  wire logic [1:0] stall_mode_i,
  input  wire logic       valid_i,
  input  wire logic       valid_oe_i,
  input  wire logic       field_i,
  input  wire logic       field_oe_i,
  output logic            drain_hold_o,
  output logic            valid_pin_o,
  output logic            field_pin_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Board pull-ups take floating pins high
  assign valid_pin_o = valid_oe_i ? valid_i : 1'b1;
  assign field_pin_o = field_oe_i ? field_i : 1'b1;
  initial drain_hold_o = 1'b0;
  // Mode 1 stalls at random, mode 2 holds the drain shut
  always @(negedge clk_i)
    drain_hold_o <= stall_mode_i[1] | (stall_mode_i[0] & $urandom_range(1));
endmodule : video_sink_model

//--- video_decoder_output_port_tb_top.sv
// Self-checking bench for the video output port.
module video_decoder_output_port_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clk_i, reset_i, soft_reset_i, output_enable_i, burst_mode_i;
  logic       video_present_i, hsync_detect_i, vsync_detect_i, pixel_valid_i;
  logic       pixel_active_i, drain_hold_i, pixel_ready_o, sample_valid_out_o;
  logic       sample_valid_out_oe_o, hsync_o, hsync_oe_o, vsync_o, vsync_oe_o;
  logic       field_o, field_oe_o, active_o, active_oe_o, valid_pin, field_pin, cb_next, f;
  logic [9:0] hsync_start_i, hsync_end_i;
  logic [7:0] luma_in_i, cb_in_i, cr_in_i, luma_out_o, chroma_out_bus_o;
  logic [1:0] stall_mode;
  logic [16:0] exp_q[$];
  logic [16:0] e;
  int         fail_count, n_tests, cycles, hi, seed;

  video_decoder_output_port i_dut (.clk_i(clk_i), .reset_i(reset_i),
    .soft_reset_i(soft_reset_i), .output_enable_i(output_enable_i),
    .burst_mode_i(burst_mode_i), .video_present_i(video_present_i),
    .hsync_detect_i(hsync_detect_i), .vsync_detect_i(vsync_detect_i),
    .hsync_start_i(hsync_start_i), .hsync_end_i(hsync_end_i),
    .pixel_valid_i(pixel_valid_i), .pixel_active_i(pixel_active_i),
    .luma_in_i(luma_in_i), .cb_in_i(cb_in_i), .cr_in_i(cr_in_i),
    .drain_hold_i(drain_hold_i), .pixel_ready_o(pixel_ready_o),
    .luma_out_o(luma_out_o), .chroma_out_bus_o(chroma_out_bus_o),
    .sample_valid_out_o(sample_valid_out_o), .sample_valid_out_oe_o(sample_valid_out_oe_o),
    .hsync_o(hsync_o), .hsync_oe_o(hsync_oe_o), .vsync_o(vsync_o), .vsync_oe_o(vsync_oe_o),
    .field_o(field_o), .field_oe_o(field_oe_o), .active_o(active_o),
    .active_oe_o(active_oe_o));

  video_sink_model i_sink (.clk_i(clk_i), .stall_mode_i(stall_mode),
    .valid_i(sample_valid_out_o), .valid_oe_i(sample_valid_out_oe_o), .field_i(field_o),
    .field_oe_i(field_oe_o), .drain_hold_o(drain_hold_i), .valid_pin_o(valid_pin),
    .field_pin_o(field_pin));

  initial
  begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp)
    begin
      $display("[ERR] %s expected %h seen %h", what, exp, got);
      fail_count++;
    end
  endtask : chk

  task automatic results();
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : results

  // Hold the sample until ready was high before the edge
  task automatic push(input logic act, input logic line);
    logic r;
    @(negedge clk_i);
    pixel_valid_i = 1'b1;
    luma_in_i = 8'($urandom);
    cb_in_i = 8'($urandom);
    cr_in_i = 8'($urandom);
    pixel_active_i = act;
    hsync_detect_i = line;
    if (line)
      cb_next = 1'b1;
    forever
    begin
      r = pixel_ready_o;
      @(posedge clk_i);
      if (r === 1'b1)
        break;
      @(negedge clk_i);
    end
    e = {act | burst_mode_i, cb_next ? cb_in_i : cr_in_i, luma_in_i < 8'h10 ? 8'h10 : luma_in_i};
    exp_q.push_back(e);
    cb_next = ~cb_next;
  endtask : push

  task automatic idle(input int n);
    @(negedge clk_i);
    pixel_valid_i = 1'b0;
    hsync_detect_i = 1'b0;
    vsync_detect_i = 1'b0;
    soft_reset_i = 1'b0;
    repeat (n) @(negedge clk_i);
  endtask : idle

  // Capture only while the valid pin is driven high
  always @(negedge clk_i)
    if (reset_i === 1'b0 && sample_valid_out_oe_o === 1'b1 && valid_pin === 1'b1)
    begin
      if (exp_q.size() == 0)
        chk("unexpected valid", 8'h00, 8'h01);
      else
      begin
        e = exp_q.pop_front();
        chk("luma", e[7:0], luma_out_o);
        chk("chroma", e[15:8], chroma_out_bus_o);
        chk("active", {7'h00, e[16]}, {7'h00, active_o});
      end
    end

  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      fail_count++;
      $display("[ERR] timeout expected done seen hang");
      results();
    end
  end

  initial
  begin
    {soft_reset_i, output_enable_i, burst_mode_i, hsync_detect_i, vsync_detect_i} = '0;
    {pixel_valid_i, pixel_active_i, luma_in_i, cb_in_i, cr_in_i} = '0;
    reset_i = 1'b1;
    video_present_i = 1'b1;
    hsync_start_i = 10'h002;
    hsync_end_i = 10'h005;
    stall_mode = 2'h0;
    cb_next = 1'b1;
    seed = $urandom(32'h3104);
    repeat (16) @(negedge clk_i);
    chk("oe in reset", 8'h00, {7'h00, field_oe_o | sample_valid_out_oe_o});
    chk("luma in reset", 8'h10, luma_out_o);
    chk("valid pin", 8'h01, {7'h00, valid_pin});
    reset_i = 1'b0;
    output_enable_i = 1'b1;
    idle(3);
    chk("oe", 8'h01, {7'h00, active_oe_o & hsync_oe_o & vsync_oe_o});
    $display("test reset done");
    stall_mode = 2'h1;
    for (int i = 0; i < 38; i++)
      push(1'($urandom), i % 19 == 0);
    idle(80);
    chk("line drained", 8'h00, 8'(exp_q.size()));
    $display("test lines done");
    burst_mode_i = 1'b1;
    idle(3);
    chk("burst active", 8'h01, {7'h00, active_o});
    repeat (4) push(1'b0, 1'b0);
    idle(30);
    burst_mode_i = 1'b0;
    idle(3);
    chk("idle active", 8'h00, {7'h00, active_o});
    $display("test burst done");
    stall_mode = 2'h2;
    idle(3);
    repeat (15) push(1'b1, 1'b0);
    idle(1);
    chk("ready at 15", 8'h01, {7'h00, pixel_ready_o});
    push(1'b1, 1'b0);
    idle(1);
    chk("ready at 16", 8'h00, {7'h00, pixel_ready_o});
    stall_mode = 2'h0;
    idle(40);
    chk("fifo drained", 8'h00, 8'(exp_q.size()));
    $display("test fill done");
    hsync_detect_i = 1'b1;
    idle(0);
    hi = 0;
    repeat (20) @(negedge clk_i) hi += hsync_o;
    chk("hsync width", 8'h03, 8'(hi));
    for (int k = 0; k < 2; k++)
    begin
      f = field_o;
      vsync_detect_i = 1'b1;
      idle(4);
      chk("field", {7'h00, ~f}, {7'h00, field_pin});
      chk("vsync", 8'h01, {7'h00, vsync_o});
    end
    $display("test sync done");
    // Line syncs with no vertical sync: the field flips on the 337th line
    f = field_o;
    for (int k = 0; k < 337; k++)
    begin
      if (k == 336)
        chk("field held", {7'h00, f}, {7'h00, field_o});
      hsync_detect_i = 1'b1;
      idle(1);
    end
    idle(3);
    chk("field timeout", {7'h00, ~f}, {7'h00, field_o});
    chk("vsync end", 8'h00, {7'h00, vsync_o});
    // One full free-running line of 858 cycles holds exactly one pulse
    video_present_i = 1'b0;
    hi = 0;
    repeat (858) @(negedge clk_i) hi += hsync_o;
    chk("free hsync", 8'h03, 8'(hi));
    video_present_i = 1'b1;
    $display("test field and free run done");
    stall_mode = 2'h2;
    idle(3);
    push(1'b1, 1'b1);
    @(negedge clk_i);
    output_enable_i = 1'b0;
    soft_reset_i = 1'b1;
    idle(2);
    exp_q.delete();
    chk("oe soft", 8'h00, {7'h00, sample_valid_out_oe_o | field_oe_o});
    chk("field pin soft", 8'h01, {7'h00, field_pin});
    stall_mode = 2'h0;
    output_enable_i = 1'b1;
    idle(10);
    push(1'b1, 1'b1);
    push(1'b0, 1'b0);
    idle(20);
    chk("flushed", 8'h00, 8'(exp_q.size()));
    $display("test soft reset done");
    results();
  end
endmodule : video_decoder_output_port_tb_top
